// File: verilog/cptr_regs.sv
`timescale 1ns/1ps

// Overview of operation
// - Each channel keeps the highest code seen, updated when a new code is larger.
// - Reading a maximum byte returns it and then clears that byte to zero, or loads it from a code for that channel in the same cycle.
// - Each channel keeps the lowest code seen, updated when a new code is smaller.
// - Reading a minimum byte returns it and then reloads that byte with all ones, or from a code for that channel in the same cycle.
// - After reset every maximum byte holds zero.
// - After reset every minimum byte holds all ones.
// - Maximum bytes sit in pairs per channel, low even, high odd, ending at 0x6F.
// - Minimum bytes sit in pairs from 0x80, low even, high odd, in channel order.
// - The statistics are read-only and no write can change them.
// - The maximum block starts with channel 0 low at 0x60 and high at 0x61.
module cptr_regs
  import cptr_pkg::*;
#(
  parameter int CODE_W = CPTR_CODE_W,
  parameter int NUM_CH = CPTR_NUM_CH
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Conversion results
  input wire logic CONV_VALID,
  input wire logic [CPTR_CH_W-1:0] CONV_CH,
  input wire logic [CODE_W-1:0] CONV_CODE,
  // Register read port
  input wire logic REG_RD,
  input wire logic [CPTR_ADDR_W-1:0] REG_ADDR,
  output logic [CPTR_BYTE_W-1:0] REG_RDATA,
  output logic REG_RVALID
);

  logic [CODE_W-1:0] max_held [NUM_CH];
  logic [CODE_W-1:0] min_held [NUM_CH];
  logic [15:0] max_w;
  logic [15:0] min_w;
  logic [3:0] blk;
  logic [CPTR_CH_W-1:0] rd_ch;
  logic rd_high;
  logic hit_max;
  logic hit_min;
  logic ch_ok;
  logic rd_max;
  logic rd_min;
  logic [7:0] sel_byte;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;

  // Address decode: block, channel and byte within the pair
  assign blk = REG_ADDR[7:CPTR_BLOCK_LSB];
  assign rd_ch = REG_ADDR[CPTR_BLOCK_LSB-1:CPTR_CH_LSB];
  assign rd_high = REG_ADDR[CPTR_HIGH_BIT];
  assign ch_ok = 32'(rd_ch) < NUM_CH;
  assign hit_max = (blk == CPTR_MAX_BASE[7:4]) && ch_ok;
  assign hit_min = (blk == CPTR_MIN_BASE[7:4]) && ch_ok;
  // Only reads reach the statistics; there is no write path
  assign rd_max = REG_RD && hit_max;
  assign rd_min = REG_RD && hit_min;

  // Per-channel trackers, one for the maximum and one for the minimum
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      logic upd;
      logic this_ch;
      assign this_ch = (32'(rd_ch) == g);
      assign upd = CONV_VALID && (32'(CONV_CH) == g);
      cptr_tracker #(
        .CODE_W(CODE_W),
        .IS_MIN(1'b0)
      ) u_max (
        .clk(CLK),
        .rst(SYS_RST),
        .upd(upd),
        .code(CONV_CODE),
        .rd_lo(rd_max && this_ch && !rd_high),
        .rd_hi(rd_max && this_ch && rd_high),
        .held(max_held[g])
      );
      cptr_tracker #(
        .CODE_W(CODE_W),
        .IS_MIN(1'b1)
      ) u_min (
        .clk(CLK),
        .rst(SYS_RST),
        .upd(upd),
        .code(CONV_CODE),
        .rd_lo(rd_min && this_ch && !rd_high),
        .rd_hi(rd_min && this_ch && rd_high),
        .held(min_held[g])
      );
    end
  endgenerate

  // Pick the addressed byte before the restart takes effect
  assign max_w = 16'(max_held[rd_ch]);
  assign min_w = 16'(min_held[rd_ch]);
  assign sel_byte = hit_max ? (rd_high ? max_w[15:8] : max_w[7:0]) :
                    hit_min ? (rd_high ? min_w[15:8] : min_w[7:0]) :
                    CPTR_UNMAPPED_DATA;
  assign rdata_next = REG_RD ? sel_byte : rdata_reg;

  // Read data register and its one-cycle valid
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rdata_reg <= CPTR_UNMAPPED_DATA;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= REG_RD;
    end
  end

  assign REG_RDATA = rdata_reg;
  assign REG_RVALID = rvalid_reg;

endmodule // cptr_regs

// File: verilog/cptr_pkg.sv
package cptr_pkg;

  // Conversion code and register widths
  localparam int CPTR_CODE_W = 16;
  localparam int CPTR_BYTE_W = 8;
  localparam int CPTR_ADDR_W = 8;
  localparam int CPTR_NUM_CH = 8;
  localparam int CPTR_CH_W = 3;

  // Register block bases: low byte even, high byte odd, two per channel
  localparam logic [7:0] CPTR_MAX_BASE = 8'h60;
  localparam logic [7:0] CPTR_MIN_BASE = 8'h80;

  // Named offsets of the tracked registers
  localparam logic [7:0] CPTR_MAX_CH4_HIGH_BYTE = 8'h69;
  localparam logic [7:0] CPTR_MAX_CH5_LOW_BYTE = 8'h6A;
  localparam logic [7:0] CPTR_MAX_CH5_HIGH_BYTE = 8'h6B;
  localparam logic [7:0] CPTR_MAX_CH6_LOW_BYTE = 8'h6C;
  localparam logic [7:0] CPTR_MAX_CH6_HIGH_BYTE = 8'h6D;
  localparam logic [7:0] CPTR_MAX_CH7_LOW_BYTE = 8'h6E;
  localparam logic [7:0] CPTR_MAX_CH7_HIGH_BYTE = 8'h6F;
  localparam logic [7:0] CPTR_MIN_CH0_LOW_BYTE = 8'h80;
  localparam logic [7:0] CPTR_MIN_CH0_HIGH_BYTE = 8'h81;
  localparam logic [7:0] CPTR_MIN_CH1_LOW_BYTE = 8'h82;
  localparam logic [7:0] CPTR_MIN_CH1_HIGH_BYTE = 8'h83;
  localparam logic [7:0] CPTR_MIN_CH2_LOW_BYTE = 8'h84;

  // Address field positions
  localparam int CPTR_BLOCK_LSB = 4;
  localparam int CPTR_CH_LSB = 1;
  localparam int CPTR_HIGH_BIT = 0;

  // Reset and restart values
  localparam logic [7:0] CPTR_MAX_RESET = 8'h00;
  localparam logic [7:0] CPTR_MIN_RESET = 8'hFF;
  localparam logic [7:0] CPTR_UNMAPPED_DATA = 8'h00;

endpackage

// File: verilog/cptr_tracker.sv
`timescale 1ns/1ps

// One channel's running extreme, held as a low and a high byte
module cptr_tracker
  import cptr_pkg::*;
#(
  parameter int CODE_W = CPTR_CODE_W,
  parameter bit IS_MIN = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // New conversion code
  input wire logic upd,
  input wire logic [CODE_W-1:0] code,
  // Read strobes for each byte
  input wire logic rd_lo,
  input wire logic rd_hi,
  // Held value
  output logic [CODE_W-1:0] held
);

  localparam logic [7:0] RESTART = IS_MIN ? CPTR_MIN_RESET : CPTR_MAX_RESET;

  logic [7:0] lo_reg;
  logic [7:0] lo_next;
  logic [7:0] hi_reg;
  logic [7:0] hi_next;
  logic [15:0] code_w;
  logic [15:0] cur_w;
  logic better;

  // Widen to the byte pair and compare with the held code
  assign code_w = 16'(code);
  assign cur_w = {hi_reg, lo_reg};
  assign better = upd && (IS_MIN ? (code_w < cur_w) : (code_w > cur_w));

  // A sample in the read cycle starts the new window, so it is not lost
  assign lo_next = rd_lo ? (upd ? code_w[7:0] : RESTART) :
                   (better ? code_w[7:0] : lo_reg);
  assign hi_next = rd_hi ? (upd ? code_w[15:8] : RESTART) :
                   (better ? code_w[15:8] : hi_reg);

  // Byte registers, reset to the restart value
  always_ff @(posedge clk) begin
    if (rst) begin
      lo_reg <= RESTART;
      hi_reg <= RESTART;
    end else begin
      lo_reg <= lo_next;
      hi_reg <= hi_next;
    end
  end

  assign held = CODE_W'(cur_w);

endmodule // cptr_tracker

// File: test/cptr_regs_chk.sv
`timescale 1ns/1ps
// Port checks of the peak register block
module cptr_regs_chk
  import cptr_pkg::*;
#(
  parameter int CODE_W = CPTR_CODE_W
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Watched ports
  input wire logic CONV_VALID,
  input wire logic [CPTR_CH_W-1:0] CONV_CH,
  input wire logic [CODE_W-1:0] CONV_CODE,
  input wire logic REG_RD,
  input wire logic [CPTR_ADDR_W-1:0] REG_ADDR,
  input wire logic [CPTR_BYTE_W-1:0] REG_RDATA,
  input wire logic REG_RVALID
);
  // Mapped blocks and common clocking
  wire logic mapped = REG_ADDR[7:4] == 4'h6 || REG_ADDR[7:4] == 4'h8;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  rd_answer_a: assert property (REG_RD |=> REG_RVALID)
    else $error("no rvalid");
  valid_pulse_a: assert property (!REG_RD |=> !REG_RVALID)
    else $error("extra rvalid");
  data_hold_a: assert property (!REG_RD |=> $stable(REG_RDATA))
    else $error("rdata moved");
  unmapped_zero_a: assert property (REG_RD && !mapped |=> !REG_RDATA)
    else $error("unmapped data");
  max_clear_a: assert property (REG_RD && REG_ADDR[7:4] == 4'h6
    && !CONV_VALID ##1 REG_RD && $stable(REG_ADDR) |=> REG_RDATA == 8'h00)
    else $error("max not cleared");
  min_reload_a: assert property (REG_RD && REG_ADDR[7:4] == 4'h8
    && !CONV_VALID ##1 REG_RD && $stable(REG_ADDR) |=> REG_RDATA == 8'hFF)
    else $error("min not reloaded");
  max_track_a: assert property ($past(CONV_VALID)
    && $past(CONV_CH) == 3'h7 && REG_RD && REG_ADDR == 8'h6F
    |=> {REG_RDATA, 8'hFF} >= $past(CONV_CODE, 2)) else $error("max low");
  min_track_a: assert property ($past(CONV_VALID)
    && $past(CONV_CH) == 3'h0 && REG_RD && REG_ADDR == 8'h81
    |=> {REG_RDATA, 8'h00} <= $past(CONV_CODE, 2)) else $error("min high");
endmodule // cptr_regs_chk

bind cptr_regs cptr_regs_chk #(.CODE_W(CODE_W)) u_chk (.CLK, .SYS_RST,
  .CONV_VALID, .CONV_CH, .CONV_CODE, .REG_RD, .REG_ADDR, .REG_RDATA,
  .REG_RVALID);

// File: test/cptr_regs_tb.sv
`timescale 1ns/1ps
// Read-port bench of the peak register block
module cptr_regs_tb
  import cptr_pkg::*;
;
  // Stimulus, observed ports and counters
  logic CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic CONV_VALID = 1'b0;
  logic [CPTR_CH_W-1:0] CONV_CH = '0;
  logic [CPTR_CODE_W-1:0] CONV_CODE = '0;
  logic REG_RD = 1'b0;
  logic [CPTR_ADDR_W-1:0] REG_ADDR = '0;
  logic [CPTR_BYTE_W-1:0] REG_RDATA;
  logic REG_RVALID;
  int n_fail = 0;
  int checks = 0;
  logic [7:0] um [4] = '{8'h5F, 8'h70, 8'h7F, 8'h90};
  logic [15:0] hi;
  logic [7:0] a;

  cptr_regs u_dut (.CLK, .SYS_RST, .CONV_VALID, .CONV_CH, .CONV_CODE,
    .REG_RD, .REG_ADDR, .REG_RDATA, .REG_RVALID);

  // Clock at 5 ns
  initial begin
    forever #2.5 CLK = ~CLK;
  end

  // Byte compare
  task cmp(input logic [7:0] ad, input logic [7:0] e, input logic [7:0] s);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("BAD rdata at %h exp %h got %h", ad, e, s);
    end
  endtask

  // Valid flag compare
  task cmp_flag(input logic e, input logic s);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("BAD rvalid exp %b got %b", e, s);
    end
  endtask

  // One read, back to back with the next call
  task rd(input logic [7:0] ad, input logic [7:0] e);
    CONV_VALID = 1'b0;
    REG_RD = 1'b1;
    REG_ADDR = ad;
    @(negedge CLK);
    cmp_flag(1'b1, REG_RVALID);
    cmp(ad, e, REG_RDATA);
  endtask

  // One conversion code
  task conv(input int ch, input logic [15:0] c);
    REG_RD = 1'b0;
    CONV_VALID = 1'b1;
    CONV_CH = 3'(ch);
    CONV_CODE = c;
    @(negedge CLK);
  endtask

  // One read with a code for the same cycle
  task rdc(input logic [7:0] ad, input logic [7:0] e, input int ch,
           input logic [15:0] c);
    REG_RD = 1'b1;
    REG_ADDR = ad;
    CONV_VALID = 1'b1;
    CONV_CH = 3'(ch);
    CONV_CODE = c;
    @(negedge CLK);
    cmp_flag(1'b1, REG_RVALID);
    cmp(ad, e, REG_RDATA);
  endtask

  // Verdict
  task end_sim;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Reset, map sweep, tracking per channel
  initial begin
    repeat (20) @(negedge CLK);
    SYS_RST = 1'b0;
    @(negedge CLK);
    for (int i = 0; i < 16; i++) begin
      rd(8'h60 + 8'(i), 8'h00);
      rd(8'h80 + 8'(i), 8'hFF);
    end
    foreach (um[i]) rd(um[i], 8'h00);
    for (int ch = 0; ch < 8; ch++) begin
      a = 8'(2 * ch);
      hi = 16'h5A10 + 16'(ch);
      conv(ch, hi);
      conv(ch, 16'h0F00);
      rd(8'h61 + a, hi[15:8]);
      rd(8'h61 + a, 8'h00);
      rd(8'h60 + a, hi[7:0]);
      rd(8'h80 + a, 8'h00);
      rd(8'h80 + a, 8'hFF);
      rd(8'h81 + a, 8'h0F);
    end
    conv(0, 16'h3344);
    rd(8'h81, 8'h33);
    rd(8'h80, 8'h44);
    // A later higher code must not raise the minimum
    conv(6, 16'h0100);
    conv(6, 16'h0200);
    rd(8'h6D, 8'h02);
    rd(8'h8D, 8'h01);
    // Read and code on one channel in the same cycle
    conv(2, 16'h4321);
    conv(5, 16'h1234);
    rdc(8'h6A, 8'h34, 5, 16'h0077);
    rd(8'h6A, 8'h77);
    rd(8'h8B, 8'h00);
    rd(8'h6B, 8'h12);
    // Second reset in mid-run clears outputs and returns statistics to their reset values
    REG_RD = 1'b0;
    SYS_RST = 1'b1;
    repeat (2) @(negedge CLK);
    SYS_RST = 1'b0;
    @(negedge CLK);
    cmp_flag(1'b0, REG_RVALID);
    cmp(8'h00, 8'h00, REG_RDATA);
    rd(8'h65, 8'h00);
    rd(8'h85, 8'hFF);
    end_sim();
  end
endmodule // cptr_regs_tb
